// ---- dv/ext_mem_model.sv ----
// Behavioural model of the external memory on the multiplexed bus.
`timescale 1ns/1ps
module ext_mem_model (
  input wire logic clk_in,
  input wire logic ale_in,
  input wire logic strobe_n_in,
  input wire logic rw_in,
  input wire logic [7:0] lo_in,
  input wire logic [7:0] mid_in,
  input wire logic [7:0] hi_in,
  input wire logic [3:0] wait_in,
  output logic [7:0] mid_out,
  output logic [7:0] hi_out,
  output logic ready_n_out,
  output logic [15:0] wdata_out
);
  logic [15:0] addr_r = 16'h0000;
  logic [15:0] last_r = 16'h0000;
  logic [3:0] cnt_r = 4'h0;
  logic drive;
  // Released lines show the inverse of their last value, never a stale copy.
  assign drive = !strobe_n_in && rw_in;
  assign {mid_out, hi_out} = drive ? {addr_r[7:0] ^ 8'h5A, addr_r[15:8]} : ~last_r;
  // Ready is low, asking for wait states, only while the strobe is low and the count runs.
  assign ready_n_out = strobe_n_in || (cnt_r >= wait_in);
  always @(posedge clk_in) begin
    if (ale_in) begin
      addr_r <= {mid_in, lo_in};
    end
    if (!strobe_n_in && !rw_in) begin
      wdata_out <= {mid_in, hi_in};
    end
    last_r <= {mid_out, hi_out};
    cnt_r <= strobe_n_in ? 4'h0 : cnt_r + {3'h0, cnt_r != 4'hF};
  end
endmodule : ext_mem_model

// ---- dv/external_bus_control_bench.sv ----
// Self-checking bench of the external bus control block.
`timescale 1ns/1ps
module external_bus_control_bench;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_in = 1'b0;
  logic req_wr_in = 1'b0;
  logic [23:0] req_addr_in = 24'h000000;
  logic [15:0] req_wdata_in = 16'h0000;
  logic hold_req_n = 1'b1;
  logic byte_mode = 1'b0;
  logic [3:0] wait_cnt = 4'h0;
  logic busy, done, grant_n, phase, ale, strobe_n, rw, bhe_n, ctrl_oe_n, mid_oe_n, hi_oe_n;
  logic ready_n;
  logic [15:0] rdata, mem_wdata, rd;
  logic [7:0] lo, mid_o, hi_o, mid_i, hi_i;
  int n_errors = 0;
  int checked = 0;
  int lows;
  always #10 clk_in = ~clk_in;
  external_bus_control #(.PHASE_DIV(2)) dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_in),
    .req_wr_in(req_wr_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .busy_out(busy), .done_out(done), .rdata_out(rdata), .hold_req_n_in(hold_req_n),
    .ready_n_in(ready_n), .byte_mode_in(byte_mode), .bus_grant_ack_n_out(grant_n),
    .phase_clk_out(phase), .ale_out(ale), .access_strobe_n_out(strobe_n), .rw_out(rw),
    .byte_high_enable_n_out(bhe_n), .addr_lo_out(lo), .ctrl_oe_n_out(ctrl_oe_n),
    .ad_mid_in(mid_i), .ad_mid_out(mid_o), .ad_mid_oe_n_out(mid_oe_n), .ad_hi_in(hi_i),
    .ad_hi_out(hi_o), .ad_hi_oe_n_out(hi_oe_n));
  ext_mem_model mem (.clk_in(clk_in), .ale_in(ale), .strobe_n_in(strobe_n), .rw_in(rw),
    .lo_in(lo), .mid_in(mid_o), .hi_in(hi_o), .wait_in(wait_cnt), .mid_out(mid_i),
    .hi_out(hi_i), .ready_n_out(ready_n), .wdata_out(mem_wdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] wd);
    int i;
    lows = 0;
    @(posedge clk_in);
    req_in <= 1'b1;
    req_wr_in <= wr;
    req_addr_in <= a;
    req_wdata_in <= wd;
    @(posedge clk_in);
    req_in <= 1'b0;
    for (i = 0; i < 400 && done !== 1'b1; i++) begin
      @(posedge clk_in);
      if (ale === 1'b1) begin
        chk(busy, 1'b1);
        chk(bhe_n, !a[0]);
        chk(rw, !wr);
        chk({hi_o, mid_o, lo, hi_oe_n}, {a, 1'b0});
      end
      if (strobe_n === 1'b0) begin
        lows++;
        chk(rw, !wr);
        chk(hi_oe_n, wr ? 1'b0 : 1'b1);
      end
    end
    chk(done, 1'b1);
    chk(busy, 1'b0);
    chk(lows > 0, 1'b1);
    rd = rdata;
  endtask : access
  task automatic t_reset;
    chk({ale, strobe_n, rw, bhe_n, grant_n, ctrl_oe_n, mid_oe_n, hi_oe_n, phase, done},
      10'b0111101100);
  endtask : t_reset
  task automatic t_write_read;
    access(1'b1, 24'h123457, 16'hBEEF);
    chk(mem_wdata, 16'hBEEF);
    access(1'b0, 24'hA56A10, 16'h0000);
    chk(rd, 16'h4A6A);
  endtask : t_write_read
  task automatic t_wait;
    wait_cnt <= 4'h9;
    access(1'b0, 24'h000101, 16'h0000);
    chk(lows >= 9, 1'b1);
    chk(rd, 16'h5B01);
    wait_cnt <= 4'h0;
  endtask : t_wait
  task automatic t_byte;
    byte_mode <= 1'b1;
    repeat (4) @(posedge clk_in);
    access(1'b0, 24'h00C3A7, 16'h0000);
    chk(rd, 16'h00C3);
    byte_mode <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : t_byte
  task automatic t_phase;
    int n;
    logic prev;
    n = 0;
    prev = phase;
    repeat (40) begin
      @(posedge clk_in);
      n += (phase !== prev);
      prev = phase;
    end
    chk(n, 20);
  endtask : t_phase
  task automatic t_hold;
    int i;
    hold_req_n <= 1'b0;
    for (i = 0; i < 20 && grant_n !== 1'b0; i++) @(posedge clk_in);
    chk(grant_n, 1'b0);
    chk({ctrl_oe_n, mid_oe_n, hi_oe_n}, 3'b111);
    repeat (30) begin
      @(posedge clk_in);
      chk({grant_n, ale}, 2'b00);
    end
    hold_req_n <= 1'b1;
    for (i = 0; i < 20 && grant_n !== 1'b1; i++) @(posedge clk_in);
    @(posedge clk_in);
    chk({grant_n, ctrl_oe_n}, 2'b10);
  endtask : t_hold
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    t_reset();
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    t_write_read();
    t_wait();
    t_byte();
    t_phase();
    t_hold();
    access(1'b0, 24'h000001, 16'h0000);
    give_verdict();
  end
endmodule : external_bus_control_bench

// ---- rtl/external_bus_control.sv ----
// Bus cycle sequencer and pin drivers of the multiplexed external bus.
`timescale 1ns/1ps
`include "ext_bus_consts.svh"

module external_bus_control #(
  parameter int PHASE_DIV = `EB_PHASE_DIV
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic req_wr_in,
  input wire logic [`EB_ADDR_W-1:0] req_addr_in,
  input wire logic [`EB_DATA_W-1:0] req_wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [`EB_DATA_W-1:0] rdata_out,
  input wire logic hold_req_n_in,
  input wire logic ready_n_in,
  input wire logic byte_mode_in,
  output logic bus_grant_ack_n_out,
  output logic phase_clk_out,
  output logic ale_out,
  output logic access_strobe_n_out,
  output logic rw_out,
  output logic byte_high_enable_n_out,
  output logic [7:0] addr_lo_out,
  output logic ctrl_oe_n_out,
  input wire logic [7:0] ad_mid_in,
  output logic [7:0] ad_mid_out,
  output logic ad_mid_oe_n_out,
  input wire logic [7:0] ad_hi_in,
  output logic [7:0] ad_hi_out,
  output logic ad_hi_oe_n_out
);
  localparam logic [`EB_PHASE_CNT_W-1:0] DIV_LAST = `EB_PHASE_CNT_W'(PHASE_DIV - 1);

  generate
    if (PHASE_DIV < 1 || PHASE_DIV > 255) begin : g_bad_div
      $error("PHASE_DIV must lie between 1 and 255.");
    end
  endgenerate

  ext_bus_pkg::bus_state_t state_r;
  logic [`EB_PHASE_CNT_W-1:0] div_cnt_r;
  logic tick;
  logic [`EB_SYNC_W-1:0] sync_v;
  logic hold_n_s;
  logic ready_n_s;
  logic byte_s;
  logic pend_r;
  logic wr_r;
  logic [`EB_ADDR_W-1:0] addr_r;
  logic [`EB_DATA_W-1:0] wdata_r;
  logic finish;
  logic [2:0] settle_r;
  logic settled;

  pin_sync #(
    .WIDTH(`EB_SYNC_W),
    .RESET_VAL(`EB_SYNC_RST)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({hold_req_n_in, ready_n_in, byte_mode_in, ad_mid_in, ad_hi_in}),
    .sync_out(sync_v)
  );

  assign hold_n_s = sync_v[`EB_HOLD_BIT];
  assign ready_n_s = sync_v[`EB_READY_BIT];
  assign byte_s = sync_v[`EB_BYTE_BIT];

  // Phase divider: one enable pulse per half period of the phase clock.
  assign tick = (div_cnt_r == DIV_LAST);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_r <= 8'h00;
    end else if (tick) begin
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_clk_out <= 1'b0;
    end else if (tick) begin
      phase_clk_out <= ~phase_clk_out;
    end
  end

  // Request capture: one access is held until the address phase of its bus cycle ends.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_r <= 1'b0;
      wr_r <= 1'b0;
      addr_r <= 24'h000000;
      wdata_r <= 16'h0000;
    end else if (req_in && !busy_out) begin
      pend_r <= 1'b1;
      wr_r <= req_wr_in;
      addr_r <= req_addr_in;
      wdata_r <= req_wdata_in;
    end else if (tick && state_r == ext_bus_pkg::ST_ADDR) begin
      pend_r <= 1'b0;
    end
  end

  assign busy_out = pend_r || (state_r != ext_bus_pkg::ST_IDLE);
  assign finish = tick && (state_r == ext_bus_pkg::ST_DATA) && ready_n_s && settled;

  // The strobe leaves one clock after the state and the pins come back through two
  // flops, so ready and read data are trusted only after the strobe has settled.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      settle_r <= 3'h0;
    end else if (state_r != ext_bus_pkg::ST_DATA) begin
      settle_r <= 3'h0;
    end else if (!settled) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  assign settled = (settle_r == `EB_SETTLE_CNT);

  // Sequencer; a hold request wins over a pending access in idle.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ext_bus_pkg::ST_IDLE;
    end else if (tick) begin
      case (state_r)
        ext_bus_pkg::ST_IDLE: begin
          if (!hold_n_s) begin
            state_r <= ext_bus_pkg::ST_HOLD;
          end else if (pend_r) begin
            state_r <= ext_bus_pkg::ST_ADDR;
          end
        end
        ext_bus_pkg::ST_ADDR: begin
          state_r <= ext_bus_pkg::ST_DATA;
        end
        ext_bus_pkg::ST_DATA: begin
          if (ready_n_s && settled) begin
            state_r <= ext_bus_pkg::ST_IDLE;
          end
        end
        ext_bus_pkg::ST_HOLD: begin
          if (hold_n_s) begin
            state_r <= ext_bus_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= ext_bus_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      rdata_out <= 16'h0000;
    end else begin
      done_out <= finish;
      if (finish && !wr_r) begin
        rdata_out[7:0] <= sync_v[`EB_HI_MSB:`EB_HI_LSB];
        rdata_out[15:8] <= byte_s ? 8'h00 : sync_v[`EB_MID_MSB:`EB_MID_LSB];
      end
    end
  end

  // Pin drivers, registered from the current bus state.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ale_out <= 1'b0;
      access_strobe_n_out <= 1'b1;
      rw_out <= 1'b1;
      byte_high_enable_n_out <= 1'b1;
      bus_grant_ack_n_out <= 1'b1;
      ctrl_oe_n_out <= 1'b0;
      addr_lo_out <= 8'h00;
      ad_mid_out <= 8'h00;
      ad_mid_oe_n_out <= 1'b1;
      ad_hi_out <= 8'h00;
      ad_hi_oe_n_out <= 1'b1;
    end else begin
      ale_out <= (state_r == ext_bus_pkg::ST_ADDR);
      access_strobe_n_out <= (state_r != ext_bus_pkg::ST_DATA);
      bus_grant_ack_n_out <= (state_r != ext_bus_pkg::ST_HOLD);
      ctrl_oe_n_out <= (state_r == ext_bus_pkg::ST_HOLD);
      case (state_r)
        ext_bus_pkg::ST_ADDR, ext_bus_pkg::ST_DATA: begin
          rw_out <= !wr_r;
          byte_high_enable_n_out <= !addr_r[0];
          addr_lo_out <= addr_r[7:0];
        end
        default: begin
          rw_out <= 1'b1;
          byte_high_enable_n_out <= 1'b1;
        end
      endcase
      case (state_r)
        ext_bus_pkg::ST_ADDR: begin
          ad_hi_out <= addr_r[23:16];
          ad_hi_oe_n_out <= 1'b0;
          ad_mid_out <= addr_r[15:8];
          ad_mid_oe_n_out <= 1'b0;
        end
        ext_bus_pkg::ST_DATA: begin
          ad_hi_out <= wdata_r[7:0];
          ad_hi_oe_n_out <= !wr_r;
          if (byte_s) begin
            ad_mid_out <= addr_r[15:8];
            ad_mid_oe_n_out <= 1'b0;
          end else begin
            ad_mid_out <= wdata_r[15:8];
            ad_mid_oe_n_out <= !wr_r;
          end
        end
        default: begin
          ad_hi_oe_n_out <= 1'b1;
          ad_mid_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  a_bhe_odd: assert property ((state_r == ext_bus_pkg::ST_DATA)
    |=> (byte_high_enable_n_out == !addr_r[0]))
    else $error("Byte high enable does not follow the address parity.");
  a_ale_addr: assert property ((state_r == ext_bus_pkg::ST_ADDR)
    |=> (ale_out && !ad_hi_oe_n_out && ad_hi_out == addr_r[23:16]))
    else $error("Address latch strobe without the address on the shared pins.");
  a_grant_hold: assert property ((state_r == ext_bus_pkg::ST_HOLD)
    |=> (!bus_grant_ack_n_out && ctrl_oe_n_out && ad_hi_oe_n_out))
    else $error("Hold state without grant or with driven pins.");
  a_hold_stays: assert property ((state_r == ext_bus_pkg::ST_HOLD && !hold_n_s)
    |=> (state_r == ext_bus_pkg::ST_HOLD))
    else $error("Hold state left while the request is still low.");
  a_wait_stretch: assert property ((state_r == ext_bus_pkg::ST_DATA && !ready_n_s)
    |=> (state_r == ext_bus_pkg::ST_DATA && !done_out))
    else $error("Data phase ended while ready was low.");
  a_phase_toggle: assert property (tick
    |=> (phase_clk_out != $past(phase_clk_out)))
    else $error("Phase clock did not toggle on its enable.");
  a_strobe_data: assert property ((state_r == ext_bus_pkg::ST_DATA)
    |=> (!access_strobe_n_out && !ale_out))
    else $error("Access strobe not low during the data phase.");
  a_rw_level: assert property ((state_r == ext_bus_pkg::ST_DATA)
    |=> (rw_out == !wr_r))
    else $error("Read/write select wrong during the data phase.");
  a_mid_byte: assert property ((state_r == ext_bus_pkg::ST_DATA && byte_s)
    |=> (ad_mid_out == addr_r[15:8] && !ad_mid_oe_n_out))
    else $error("Middle address lost in 8-bit mode.");
  a_addr_first: assert property ((state_r == ext_bus_pkg::ST_ADDR && tick)
    |=> (state_r == ext_bus_pkg::ST_DATA))
    else $error("Address phase not followed by the data phase.");
  a_hold_release: assert property ((state_r == ext_bus_pkg::ST_HOLD)
    |=> (ctrl_oe_n_out && ad_mid_oe_n_out && ad_hi_oe_n_out))
    else $error("Control pins not released in hold.");

  c_read_done: cover property (done_out && !wr_r);
  c_write_done: cover property (done_out && wr_r);
  c_wait_seen: cover property (state_r == ext_bus_pkg::ST_DATA && !ready_n_s && tick);
  c_hold_seen: cover property (state_r == ext_bus_pkg::ST_HOLD);
endmodule : external_bus_control

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1.");
    end
  endgenerate

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_r <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : pin_sync

// ---- shared/ext_bus_consts.svh ----
// Timing counts, widths and reset values of the external bus control block.
`ifndef EXT_BUS_CONSTS_SVH
`define EXT_BUS_CONSTS_SVH
`define EB_ADDR_W 24
`define EB_DATA_W 16
`define EB_PHASE_DIV 2
`define EB_PHASE_CNT_W 8
`define EB_SYNC_W 19
`define EB_SYNC_RST 19'h6FFFB
`define EB_SETTLE_CNT 3'h3
`define EB_HOLD_BIT 18
`define EB_READY_BIT 17
`define EB_BYTE_BIT 16
`define EB_MID_MSB 15
`define EB_MID_LSB 8
`define EB_HI_MSB 7
`define EB_HI_LSB 0
`endif

// ---- shared/ext_bus_pkg.sv ----
// Types shared by the external bus control block.
package ext_bus_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_HOLD
  } bus_state_t;
endpackage : ext_bus_pkg
